// [core/mss_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mss_consts.svh"
module mss_sequencer
    import mss_pkg::*;
#(
    parameter int NCH = 16,
    parameter int CW  = 5,
    parameter int DW  = 16,
    parameter int LW  = 24
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               conv_start,
    output logic      [CW-1:0] conv_channel,
    output logic      [1:0]    conv_terminal,
    input  wire logic          conv_done,
    input  wire logic [DW-1:0] conv_data,
    output logic               smp_valid,
    output logic      [DW-1:0] smp_data,
    output logic      [CW-1:0] smp_channel,
    output logic      [LW-1:0] smp_index,
    output logic               irq
);
    localparam int IW = $clog2(NCH);

    mss_state_t        state_q, state_d;
    logic [1:0]        mode_q, mode_d, term_q, term_d;
    logic [15:0]       pace_q, pace_d, tmr_q, tmr_d;
    logic [LW-1:0]     len_q, len_d, total_q, total_d, wptr_q, wptr_d;
    logic [LW:0]       fill_q, fill_d;
    logic [IW:0]       llen_q, llen_d;
    logic [IW-1:0]     idx_q, idx_d;
    logic [CW-1:0]     list_q [NCH];
    logic [CW-1:0]     list_d [NCH];
    logic              stop_q, stop_d, ovf_q, ovf_d;
    logic [2:0]        ist_q, ist_d, ien_q, ien_d;
    logic [DW+CW-1:0]  prev_q, prev_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pready_d, pslverr_q, pslverr_d;
    logic              cs_q, cs_d, sv_q, sv_d, irq_q, irq_d;
    logic [CW-1:0]     cch_q, cch_d, sch_q, sch_d;
    logic [DW-1:0]     sd_q, sd_d;
    logic [LW-1:0]     si_q, si_d;

    logic wr, rd, start_w, stop_w, clr_ovf, got, last_fin, full, hit, in_list;
    logic [2:0]     ev;
    logic [CW-1:0]  next_ch;
    logic [IW-1:0]  nidx;

    // paired inputs use half the channel numbers
    function automatic logic [CW-1:0] ch_map(input logic [CW-1:0] c, input logic [1:0] t);
        logic [CW-1:0] r;
        r = c;
        if (t == MSS_PAIRED_INPUT)
            r[CW-1] = 1'b0;
        return r;
    endfunction : ch_map

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign conv_start    = cs_q;
    assign conv_channel  = cch_q;
    assign conv_terminal = term_q;
    assign smp_valid     = sv_q;
    assign smp_data      = sd_q;
    assign smp_channel   = sch_q;
    assign smp_index     = si_q;
    assign irq           = irq_q;

    always_comb begin
        wr       = psel & penable & pready_q & pwrite;
        rd       = psel & penable & ~pready_q & ~pwrite;
        start_w  = wr && paddr == `MSS_A_CTRL && pwdata[`MSS_CTRL_START];
        stop_w   = wr && paddr == `MSS_A_CTRL && pwdata[`MSS_CTRL_STOP];
        clr_ovf  = wr && paddr == `MSS_A_IRQ_CLR && pwdata[`MSS_IRQ_OVF];
        got      = state_q == MSS_CONV && conv_done;
        last_fin = mode_q == MSS_FINITE && total_q + 1'b1 >= len_q;
        // capture length bounds unread data in streaming modes
        full     = (mode_q == MSS_CONTINUOUS || mode_q == MSS_RECORD) && fill_q >= {1'b0, len_q};
        hit      = got & ~full;
        in_list  = paddr >= `MSS_A_LIST && 32'(paddr) < 32'(`MSS_A_LIST) + 4 * NCH;
        nidx     = (32'(idx_q) + 1 >= 32'(llen_q)) ? '0 : IW'(idx_q + 1'b1);
        next_ch  = ch_map(list_q[nidx], term_q);
        ev       = '0;
        // defaults hold state
        state_d = state_q;
        mode_d  = mode_q;
        term_d  = term_q;
        pace_d  = pace_q;
        tmr_d   = tmr_q;
        len_d   = len_q;
        total_d = total_q;
        wptr_d  = wptr_q;
        fill_d  = fill_q;
        llen_d  = llen_q;
        idx_d   = idx_q;
        list_d  = list_q;
        stop_d  = stop_q;
        ovf_d   = ovf_q;
        ien_d   = ien_q;
        prev_d  = prev_q;
        cs_d    = 1'b0;
        cch_d   = cch_q;
        sv_d    = 1'b0;
        sch_d   = sch_q;
        sd_d    = sd_q;
        si_d    = si_q;
        pready_d  = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;

        // configuration only while idle, IRQ enables excepted; other fields have no effect mid-run
        if (wr && state_q == MSS_IDLE) begin
            unique case (paddr)
                `MSS_A_CTRL: begin
                    mode_d = pwdata[`MSS_CTRL_MODE];
                    term_d = pwdata[`MSS_CTRL_TERM];
                end
                `MSS_A_PACE:    pace_d = pwdata[15:0];
                `MSS_A_LENGTH:  len_d  = pwdata[LW-1:0];
                `MSS_A_LISTLEN: llen_d = (pwdata[IW:0] == '0) ? (IW+1)'(1) :
                                         (32'(pwdata[IW:0]) > NCH) ? (IW+1)'(NCH) : pwdata[IW:0];
                default: if (in_list) list_d[IW'((paddr - `MSS_A_LIST) >> 2)] = pwdata[CW-1:0];
            endcase
        end
        if (wr && paddr == `MSS_A_IRQ_EN)
            ien_d = pwdata[2:0];
        if (psel & penable & pready_d) begin
            pslverr_d = !(paddr[1:0] == 2'h0 && (paddr <= `MSS_A_IRQ_EN || in_list));
        end
        if (rd) begin
            unique case (paddr)
                `MSS_A_CTRL:    prdata_d = {26'h0, term_q, mode_q, 2'h0};
                `MSS_A_PACE:    prdata_d = {16'h0, pace_q};
                `MSS_A_LENGTH:  prdata_d = 32'(len_q);
                `MSS_A_LISTLEN: prdata_d = 32'(llen_q);
                `MSS_A_STATUS:  prdata_d = {fill_q[LW-1:0], 5'h0, stop_q, ovf_q,
                                            state_q != MSS_IDLE};
                // preview of the newest sample while streaming
                `MSS_A_PREVIEW: prdata_d = 32'(prev_q);
                `MSS_A_CONSUME: prdata_d = 32'(total_q);
                `MSS_A_IRQ_ST:  prdata_d = {29'h0, ist_q};
                `MSS_A_IRQ_EN:  prdata_d = {29'h0, ien_q};
                default: prdata_d = in_list ? 32'(list_q[IW'((paddr - `MSS_A_LIST) >> 2)]) : 32'h0;
            endcase
        end

        // host frees buffer room; a sample in the same cycle still counts
        if (wr && paddr == `MSS_A_CONSUME)
            fill_d = (fill_q > {1'b0, pwdata[LW-1:0]}) ? fill_q - {1'b0, pwdata[LW-1:0]} : '0;
        if (hit && (mode_q == MSS_CONTINUOUS || mode_q == MSS_RECORD))
            fill_d = fill_d + 1'b1;

        unique case (state_q)
            MSS_IDLE: begin
                // start acts as software trigger; refused while overflow stands
                if (start_w && !ovf_q) begin
                    state_d = MSS_CONV;
                    cs_d    = 1'b1;
                    cch_d   = ch_map(list_q[0], term_d);
                    idx_d   = '0;
                    total_d = '0;
                    wptr_d  = '0;
                    fill_d  = '0;
                    stop_d  = 1'b0;
                end
            end
            MSS_WAIT: begin
                // nothing in flight, stop is immediate
                if (stop_w) begin
                    state_d = MSS_IDLE;
                    ev[`MSS_IRQ_DONE] = 1'b1;
                end else if (tmr_q == '0) begin
                    // next conversion only after the last has finished
                    state_d = MSS_CONV;
                    cs_d    = 1'b1;
                    cch_d   = ch_map(list_q[idx_q], term_q);
                end else
                    tmr_d = tmr_q - 1'b1;
            end
            MSS_CONV: begin
                if (stop_w)
                    stop_d = 1'b1;
                if (got) begin
                    if (full) begin
                        // reader fell behind: flag and drop the sample
                        ovf_d   = 1'b1;
                        state_d = MSS_IDLE;
                        ev[`MSS_IRQ_OVF] = 1'b1;
                    end else begin
                        // result tagged with the channel it converted, after the paired map
                        sv_d    = 1'b1;
                        sd_d    = conv_data;
                        sch_d   = cch_q;
                        si_d = (mode_q == MSS_FINITE || mode_q == MSS_SINGLE) ? total_q : wptr_q;
                        prev_d  = {cch_q, conv_data};
                        total_d = total_q + 1'b1;
                        // circular write index wraps at capture length
                        wptr_d  = (wptr_q + 1'b1 >= len_q) ? '0 : wptr_q + 1'b1;
                        idx_d   = nidx;
                        ev[`MSS_IRQ_SAMPLE] = 1'b1;
                        // finite ends at exact count; single gives one
                        if (last_fin || mode_q == MSS_SINGLE || stop_q || stop_w) begin
                            state_d = MSS_IDLE;
                            ev[`MSS_IRQ_DONE] = 1'b1;
                        end else if (pace_q <= 16'h0001) begin
                            // conversion pace sets cycles from done to the next start
                            state_d = MSS_CONV;
                            cs_d    = 1'b1;
                            cch_d   = next_ch;
                        end else begin
                            state_d = MSS_WAIT;
                            tmr_d   = pace_q - 16'h0002;
                        end
                    end
                end
            end
        endcase
        // overflow sticks until cleared; a new overflow beats the clear
        if (clr_ovf && !ev[`MSS_IRQ_OVF])
            ovf_d = 1'b0;
        ist_d = (ist_q & ~((wr && paddr == `MSS_A_IRQ_CLR) ? pwdata[2:0] : 3'h0)) | ev;
        irq_d = |(ist_d & ien_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= MSS_IDLE;
            mode_q    <= MSS_CONTINUOUS;
            term_q    <= MSS_GROUNDED_SE;
            pace_q    <= `MSS_PACE_RST;
            tmr_q     <= '0;
            len_q     <= `MSS_LEN_RST;
            total_q   <= '0;
            wptr_q    <= '0;
            fill_q    <= '0;
            llen_q    <= (IW+1)'(1);
            idx_q     <= '0;
            list_q    <= '{default: '0};
            stop_q    <= 1'b0;
            ovf_q     <= 1'b0;
            ist_q     <= '0;
            ien_q     <= '0;
            prev_q    <= '0;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            cs_q      <= 1'b0;
            cch_q     <= '0;
            sv_q      <= 1'b0;
            sch_q     <= '0;
            sd_q      <= '0;
            si_q      <= '0;
            irq_q     <= 1'b0;
        end else if (ce) begin
            state_q   <= state_d;
            mode_q    <= mode_d;
            term_q    <= term_d;
            pace_q    <= pace_d;
            tmr_q     <= tmr_d;
            len_q     <= len_d;
            total_q   <= total_d;
            wptr_q    <= wptr_d;
            fill_q    <= fill_d;
            llen_q    <= llen_d;
            idx_q     <= idx_d;
            list_q    <= list_d;
            stop_q    <= stop_d;
            ovf_q     <= ovf_d;
            ist_q     <= ist_d;
            ien_q     <= ien_d;
            prev_q    <= prev_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            cs_q      <= cs_d;
            cch_q     <= cch_d;
            sv_q      <= sv_d;
            sch_q     <= sch_d;
            sd_q      <= sd_d;
            si_q      <= si_d;
            irq_q     <= irq_d;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    property p_one_conv;
        conv_start |-> state_q == MSS_CONV && ($past(state_q) != MSS_CONV || $past(got));
    endproperty
    a_one_conv: assert property (p_one_conv) else $error("overlapping conversion start");
    property p_list_order;
        got && !full |=> smp_valid && smp_channel == $past(ch_map(list_q[idx_q], term_q));
    endproperty
    a_list_order: assert property (p_list_order) else $error("sample channel out of order");
    property p_overflow;
        got && full |=> ovf_q && state_q == MSS_IDLE && !smp_valid;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");
    property p_finite_end;
        got && !full && mode_q == MSS_FINITE && last_fin |=> state_q == MSS_IDLE ##1 !conv_start;
    endproperty
    a_finite_end: assert property (p_finite_end) else $error("finite run did not end");
    property p_single;
        got && mode_q == MSS_SINGLE |=> state_q == MSS_IDLE && ist_q[`MSS_IRQ_DONE];
    endproperty
    a_single: assert property (p_single) else $error("single point gave more than one");
    property p_paired;
        conv_start && term_q == MSS_PAIRED_INPUT |-> !conv_channel[CW-1];
    endproperty
    a_paired: assert property (p_paired) else $error("paired mode channel out of range");
    property p_trigger;
        state_q == MSS_IDLE && start_w && !ovf_q
            |=> conv_start && conv_channel == ch_map(list_q[0], term_q);
    endproperty
    a_trigger: assert property (p_trigger) else $error("start did not convert at once");
    property p_ovf_hold;
        ovf_q && !clr_ovf |=> ovf_q && !smp_valid;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag not held");
    property p_stop;
        state_q == MSS_WAIT && stop_w |=> state_q == MSS_IDLE [*2];
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not return to idle");
endmodule : mss_sequencer
`default_nettype wire

// [core/mss_consts.svh]
`ifndef MSS_CONSTS_SVH
`define MSS_CONSTS_SVH
`define MSS_A_CTRL     8'h00
`define MSS_A_PACE     8'h04
`define MSS_A_LENGTH   8'h08
`define MSS_A_LISTLEN  8'h0C
`define MSS_A_STATUS   8'h10
`define MSS_A_PREVIEW  8'h14
`define MSS_A_CONSUME  8'h18
`define MSS_A_IRQ_ST   8'h1C
`define MSS_A_IRQ_CLR  8'h20
`define MSS_A_IRQ_EN   8'h24
`define MSS_A_LIST     8'h40
`define MSS_CTRL_START 0
`define MSS_CTRL_STOP  1
`define MSS_CTRL_MODE  3:2
`define MSS_CTRL_TERM  5:4
`define MSS_IRQ_SAMPLE 0
`define MSS_IRQ_DONE   1
`define MSS_IRQ_OVF    2
`define MSS_PACE_RST   16'h0001
`define MSS_LEN_RST    24'h000400
`endif

// [core/mss_pkg.sv]
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_IDLE = 3'b001,
        MSS_WAIT = 3'b010,
        MSS_CONV = 3'b100
    } mss_state_t;
    typedef enum logic [1:0] {
        MSS_CONTINUOUS = 2'h0,
        MSS_FINITE     = 2'h1,
        MSS_SINGLE     = 2'h2,
        MSS_RECORD     = 2'h3
    } mss_mode_t;
    typedef enum logic [1:0] {
        MSS_PAIRED_INPUT   = 2'h0,
        MSS_GROUNDED_SE    = 2'h1,
        MSS_SENSE_REF_SE   = 2'h2
    } mss_term_t;
endpackage : mss_pkg

// [verif/mss_conv_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mss_conv_model #(
    parameter int CW = 5
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          slow,
    input  wire logic          conv_start,
    input  wire logic [CW-1:0] conv_channel,
    output logic               conv_done,
    output logic      [15:0]   conv_data
);
    logic          busy_q;
    logic [3:0]    cnt_q;
    logic [CW-1:0] ch_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q    <= 1'b0;
            cnt_q     <= 4'h0;
            ch_q      <= '0;
            conv_done <= 1'b0;
            conv_data <= 16'hFFFF;
        end else begin
            conv_done <= 1'b0;
            // data is void outside the done pulse, keep it moving
            conv_data <= ~conv_data;
            if (conv_start && !busy_q) begin
                busy_q <= 1'b1;
                ch_q   <= conv_channel;
                cnt_q  <= slow ? 4'h9 : 4'h1;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q    <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= 16'h5A00 | 16'(ch_q);
            end
        end
    end
endmodule : mss_conv_model
`default_nettype wire

// [verif/mss_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mss_consts.svh"
module mss_sequencer_tb import mss_pkg::*;;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        slow    = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, conv_start, conv_done, smp_valid, irq, e;
    logic [4:0]  conv_channel, smp_channel;
    logic [1:0]  conv_terminal, last_term;
    logic [15:0] conv_data, smp_data;
    logic [23:0] smp_index;
    int          errors, checks_done, n_start, t_done, gap, cyc;
    logic [4:0]  s_ch[$];
    logic [15:0] s_dat[$];
    logic [23:0] s_idx[$];
    logic [4:0]  lst[4] = '{5'h02, 5'h03, 5'h01, 5'h00};
    always #5 pclk = ~pclk;
    mss_sequencer dut_u (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_terminal(conv_terminal), .conv_done(conv_done), .conv_data(conv_data),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_channel(smp_channel),
        .smp_index(smp_index), .irq(irq));
    mss_conv_model conv_u (
        .pclk(pclk), .presetn(presetn), .slow(slow), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data));
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (conv_start === 1'b1) begin
            n_start   = n_start + 1;
            gap       = cyc - t_done;
            last_term = conv_terminal;
        end
        if (conv_done === 1'b1) t_done = cyc;
        if (smp_valid === 1'b1) begin
            s_ch.push_back(smp_channel);
            s_dat.push_back(smp_data);
            s_idx.push_back(smp_index);
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) errors++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask : rdc
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            xfer(1'b0, `MSS_A_STATUS, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 400);
        if (n >= 400) errors++;
    endtask : wait_idle
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask : settle
    task automatic run(input logic [1:0] m, input logic [1:0] t);
        wr(`MSS_A_CTRL, {26'h0, t, m, 2'b00});
        wr(`MSS_A_IRQ_CLR, 32'h7);
        s_ch.delete();
        s_dat.delete();
        s_idx.delete();
        n_start = 0;
        wr(`MSS_A_CTRL, {26'h0, t, m, 2'b01});
    endtask : run
    task automatic tally_and_finish();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({30'h0, conv_terminal}, 32'h1);
        rdc(`MSS_A_PACE, 32'hFFFF, 32'h1);
        rdc(`MSS_A_LENGTH, 32'hFF_FFFF, 32'h400);
        rdc(`MSS_A_IRQ_CLR, 32'hFFFF_FFFF, 32'h0);
        xfer(1'b0, 8'h30, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 4; i++) wr(8'(`MSS_A_LIST + 4 * i), {27'h0, lst[i]});
        wr(`MSS_A_LISTLEN, 32'h4);
        wr(`MSS_A_LENGTH, 32'h6);
        wr(`MSS_A_PACE, 32'h5);
        wr(`MSS_A_IRQ_EN, 32'h0);
        run(MSS_FINITE, MSS_GROUNDED_SE);
        wait_idle();
        chk(32'(s_ch.size()), 32'h6);
        for (int i = 0; i < s_ch.size() && i < 6; i++) begin
            chk({27'h0, s_ch[i]}, {27'h0, lst[i % 4]});
            chk({16'h0, s_dat[i]}, 32'h5A00 + 32'(lst[i % 4]));
            chk({8'h0, s_idx[i]}, 32'(i));
        end
        chk(32'(gap), 32'h5);
        rdc(`MSS_A_IRQ_ST, 32'h7, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(`MSS_A_IRQ_EN, 32'h2);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(`MSS_A_IRQ_CLR, 32'h2);
        settle();
        chk({31'h0, irq}, 32'h0);
        $display("finite test done");
        wr(`MSS_A_LIST, 32'h13);
        wr(`MSS_A_LISTLEN, 32'h1);
        slow <= 1'b1;
        for (int t = 0; t < 3; t++) begin
            run(MSS_SINGLE, 2'(t));
            wait_idle();
            chk(32'(s_ch.size()), 32'h1);
            chk({27'h0, s_ch[0]}, (t == 0) ? 32'h3 : 32'h13);
            chk({30'h0, last_term}, 32'(t));
        end
        $display("single test done");
        slow <= 1'b0;
        wr(`MSS_A_LENGTH, 32'h3);
        wr(`MSS_A_PACE, 32'h1);
        wr(`MSS_A_IRQ_EN, 32'h4);
        run(MSS_CONTINUOUS, MSS_GROUNDED_SE);
        wait_idle();
        chk(32'(s_ch.size()), 32'h3);
        rdc(`MSS_A_STATUS, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(`MSS_A_CTRL, 32'h11);
        settle();
        rdc(`MSS_A_STATUS, 32'h3, 32'h2);
        chk(32'(s_ch.size()), 32'h3);
        wr(`MSS_A_IRQ_CLR, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h0);
        rdc(`MSS_A_STATUS, 32'h2, 32'h0);
        $display("overflow test done");
        wr(`MSS_A_LENGTH, 32'h8);
        wr(`MSS_A_PACE, 32'h14);
        run(MSS_RECORD, MSS_GROUNDED_SE);
        repeat (60) wr(`MSS_A_CONSUME, 32'h1);
        wr(`MSS_A_PACE, 32'h9);
        wr(`MSS_A_CTRL, 32'h1E);
        wait_idle();
        chk(32'(n_start), 32'(s_ch.size()));
        chk(32'(s_ch.size() > 8), 32'h1);
        for (int i = 0; i < s_idx.size(); i++) chk({8'h0, s_idx[i]}, 32'(i % 8));
        rdc(`MSS_A_PACE, 32'hFFFF, 32'h14);
        rdc(`MSS_A_STATUS, 32'h2, 32'h0);
        xfer(1'b0, `MSS_A_PREVIEW, 32'h0);
        if (s_dat.size() > 0) chk({16'h0, r[15:0]}, {16'h0, s_dat[$]});
        $display("record test done");
        tally_and_finish();
    end
endmodule : mss_sequencer_tb
`default_nettype wire
